// File: hdl/stps_pkg.sv
// constants, register map and timer modes for the serial/timer pin function select
package stps_pkg;
	// ----------------------------------------
	// bus geometry
	// ----------------------------------------
	localparam int AW = 8;
	localparam int DW = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [AW-1:0] OFS_PD_DIR = 8'h00;
	localparam logic [AW-1:0] OFS_PD_CTL = 8'h04;
	localparam logic [AW-1:0] OFS_PD_OUT = 8'h08;
	localparam logic [AW-1:0] OFS_PE_DIR = 8'h0c;
	localparam logic [AW-1:0] OFS_PE_CTL = 8'h10;
	localparam logic [AW-1:0] OFS_PE_OUT = 8'h14;
	localparam logic [AW-1:0] OFS_TM0 = 8'h18;
	localparam logic [AW-1:0] OFS_TM_STEP = 8'h04;
	localparam logic [AW-1:0] OFS_PIN_LVL = 8'h24;
	// ----------------------------------------
	// field layout
	// ----------------------------------------
	localparam int PD_LSB = 4;
	localparam int PD_W = 2;
	localparam int PE_W = 3;
	localparam int TM_N = 3;
	localparam int NPIN = 8;
	localparam int PIN_PD4 = 0;
	localparam int PIN_PD5 = 1;
	localparam int PIN_PE0 = 2;
	localparam int PIN_PE1 = 3;
	localparam int PIN_PE2 = 4;
	localparam int PIN_TM0 = 5;
	localparam int TM_MODE_LSB = 0;
	localparam int TM_MODE_W = 3;
	localparam int TM_GDIR_BIT = 4;
	localparam int TM_GOUT_BIT = 5;
	localparam int TM_LVL_BIT = 8;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [PD_W-1:0] RST_PD = 2'h0;
	localparam logic [PE_W-1:0] RST_PE = 3'h0;
	localparam logic [TM_MODE_W-1:0] RST_TM_MODE = 3'h0;
	// ----------------------------------------
	// timer pin modes; codes 6 and 7 act as gpio
	// ----------------------------------------
	typedef enum logic [TM_MODE_W-1:0] {TM_GPIO, TM_TIMER, TM_PWM, TM_WDOG, TM_EVENT, TM_MEAS} stps_tmode_e;

	function automatic logic tm_drives(input logic [TM_MODE_W-1:0] m);
		unique case (m)
			TM_TIMER, TM_PWM, TM_WDOG: tm_drives = 1'b1;
			default: tm_drives = 1'b0;
		endcase
	endfunction

	function automatic logic tm_periph(input logic [TM_MODE_W-1:0] m);
		unique case (m)
			TM_TIMER, TM_PWM, TM_WDOG, TM_EVENT, TM_MEAS: tm_periph = 1'b1;
			default: tm_periph = 1'b0;
		endcase
	endfunction
endpackage

// File: hdl/stps_pin_cell.sv
// one multiplexed pin: gpio or peripheral drive, registered
`timescale 1ns/10ps
`default_nettype none
module stps_pin_cell (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// selection and sources
	input wire logic sel,
	input wire logic gpio_dir,
	input wire logic gpio_out,
	input wire logic per_oe,
	input wire logic per_out,
	// pin
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe,
	// sampled level
	output logic lvl,
	output logic per_in
);
	logic pin_o_r, pin_o_nxt, pin_oe_r, pin_oe_nxt;
	logic lvl_r, lvl_nxt, per_in_r, per_in_nxt;

	// ----------------------------------------
	// mux
	// ----------------------------------------
	always_comb begin
		pin_oe_nxt = sel ? per_oe : gpio_dir;
		pin_o_nxt = sel ? per_out : gpio_out;
		lvl_nxt = pin_i;
		per_in_nxt = sel & pin_i;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pin_o_r <= 1'b0;
			pin_oe_r <= 1'b0;
			lvl_r <= 1'b0;
			per_in_r <= 1'b0;
		end else begin
			pin_o_r <= pin_o_nxt;
			pin_oe_r <= pin_oe_nxt;
			lvl_r <= lvl_nxt;
			per_in_r <= per_in_nxt;
		end
	end

	assign pin_o = pin_o_r;
	assign pin_oe = pin_oe_r;
	assign lvl = lvl_r;
	assign per_in = per_in_r;
endmodule
`default_nettype wire

// File: hdl/stps_pin_select.sv
// serial and timer pin function select with axi4-lite registers
//
// Overview of operation
// - after reset port D bits four and five are gpio
// - port D gpio pin direction comes from port D direction register
// - port D control bit set hands pin to the sync serial port
// - sync receive pin is an input, feeding the receive shifter
// - sync transmit pin drives while the port transmits
// - port E pins reset to gpio, direction from port E direction register
// - port E control bit set routes pin to async rx, tx or clock
// - async interface is full duplex: rx pin in, tx pin out
// - async clock pin is input or driven output, per interface
// - three identical independent timers, each with its own pin
// - event counter and measurement modes make the timer pin input
// - watchdog, timer and pulse modes drive the timer pin
// - timer pins reset to gpio input; only control writes change that
`timescale 1ns/10ps
`default_nettype none
module stps_pin_select import stps_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// axi4-lite write address
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// port D pins
	input wire logic portd_bit_four_i,
	output logic portd_bit_four_o,
	output logic portd_bit_four_oe,
	input wire logic portd_bit_five_i,
	output logic portd_bit_five_o,
	output logic portd_bit_five_oe,
	// port E pins
	input wire logic porte_bit_zero_i,
	output logic porte_bit_zero_o,
	output logic porte_bit_zero_oe,
	input wire logic porte_bit_one_i,
	output logic porte_bit_one_o,
	output logic porte_bit_one_oe,
	input wire logic porte_bit_two_i,
	output logic porte_bit_two_o,
	output logic porte_bit_two_oe,
	// timer pins
	input wire logic timer_zero_pin_i,
	output logic timer_zero_pin_o,
	output logic timer_zero_pin_oe,
	input wire logic timer_one_pin_i,
	output logic timer_one_pin_o,
	output logic timer_one_pin_oe,
	input wire logic timer_two_pin_i,
	output logic timer_two_pin_o,
	output logic timer_two_pin_oe,
	// enhanced_sync_serial_port side
	output logic sync_rx_data,
	input wire logic sync_tx_busy,
	input wire logic sync_tx_data,
	// async_serial_interface side
	output logic async_rx_data,
	input wire logic async_tx_data,
	input wire logic async_clk_drive,
	input wire logic async_clk_out,
	output logic async_clk_in,
	// timer cores
	output logic [TM_N*TM_MODE_W-1:0] timer_mode,
	input wire logic [TM_N-1:0] timer_out,
	output logic [TM_N-1:0] timer_in
);
	// ----------------------------------------
	// register file state
	// ----------------------------------------
	logic [PD_W-1:0] pd_dir_r, pd_dir_nxt, pd_ctl_r, pd_ctl_nxt, pd_out_r, pd_out_nxt;
	logic [PE_W-1:0] pe_dir_r, pe_dir_nxt, pe_ctl_r, pe_ctl_nxt, pe_out_r, pe_out_nxt;
	logic [TM_MODE_W-1:0] tm_mode_r [TM_N];
	logic [TM_MODE_W-1:0] tm_mode_nxt [TM_N];
	logic [TM_N-1:0] tm_gdir_r, tm_gdir_nxt, tm_gout_r, tm_gout_nxt;
	// ----------------------------------------
	// bus state
	// ----------------------------------------
	logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [AW-1:0] aw_addr_r, aw_addr_nxt;
	logic [DW-1:0] w_data_r, w_data_nxt;
	logic w_lane0_r, w_lane0_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [DW-1:0] rdata_r, rdata_nxt, rd_word;
	logic wr_fire, ar_fire;
	// ----------------------------------------
	// pin vectors
	// ----------------------------------------
	logic [NPIN-1:0] sel, gdir, gout, poe, pout, pin_i, pin_o, pin_oe, lvl, per_in;

	function automatic logic [AW-1:0] tm_ofs(input int i);
		tm_ofs = OFS_TM0 + AW'(i) * OFS_TM_STEP;
	endfunction

	function automatic logic addr_ok(input logic [AW-1:0] a);
		addr_ok = 1'b0;
		if (a == OFS_PD_DIR || a == OFS_PD_CTL || a == OFS_PD_OUT)
			addr_ok = 1'b1;
		if (a == OFS_PE_DIR || a == OFS_PE_CTL || a == OFS_PE_OUT)
			addr_ok = 1'b1;
		if (a == OFS_PIN_LVL)
			addr_ok = 1'b1;
		for (int i = 0; i < TM_N; i++) begin
			if (a == tm_ofs(i))
				addr_ok = 1'b1;
		end
	endfunction

	// ----------------------------------------
	// axi4-lite handshakes
	// ----------------------------------------
	// one write outstanding; address and data taken in either order
	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready = !w_have_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
	assign ar_fire = s_axi_arvalid && s_axi_arready;

	always_comb begin
		aw_have_nxt = aw_have_r;
		aw_addr_nxt = aw_addr_r;
		w_have_nxt = w_have_r;
		w_data_nxt = w_data_r;
		w_lane0_nxt = w_lane0_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		pd_dir_nxt = pd_dir_r;
		pd_ctl_nxt = pd_ctl_r;
		pd_out_nxt = pd_out_r;
		pe_dir_nxt = pe_dir_r;
		pe_ctl_nxt = pe_ctl_r;
		pe_out_nxt = pe_out_r;
		tm_mode_nxt = tm_mode_r;
		tm_gdir_nxt = tm_gdir_r;
		tm_gout_nxt = tm_gout_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = {s_axi_awaddr[AW-1:2], 2'h0};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_lane0_nxt = s_axi_wstrb[0];
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
		if (wr_fire) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = addr_ok(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
			// all fields sit in byte lane 0
			if (w_lane0_r) begin
				if (aw_addr_r == OFS_PD_CTL)
					pd_ctl_nxt = w_data_r[PD_LSB +: PD_W];
				if (aw_addr_r == OFS_PD_DIR)
					pd_dir_nxt = w_data_r[PD_LSB +: PD_W];
				if (aw_addr_r == OFS_PD_OUT)
					pd_out_nxt = w_data_r[PD_LSB +: PD_W];
				if (aw_addr_r == OFS_PE_CTL)
					pe_ctl_nxt = w_data_r[PE_W-1:0];
				if (aw_addr_r == OFS_PE_DIR)
					pe_dir_nxt = w_data_r[PE_W-1:0];
				if (aw_addr_r == OFS_PE_OUT)
					pe_out_nxt = w_data_r[PE_W-1:0];
				// only control writes change timer pins
				for (int i = 0; i < TM_N; i++) begin
					if (aw_addr_r == tm_ofs(i)) begin
						tm_mode_nxt[i] = w_data_r[TM_MODE_LSB +: TM_MODE_W];
						tm_gdir_nxt[i] = w_data_r[TM_GDIR_BIT];
						tm_gout_nxt[i] = w_data_r[TM_GOUT_BIT];
					end
				end
			end
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb begin
		rd_word = '0;
		if (s_axi_araddr[AW-1:2] == OFS_PD_DIR[AW-1:2])
			rd_word[PD_LSB +: PD_W] = pd_dir_r;
		if (s_axi_araddr[AW-1:2] == OFS_PD_CTL[AW-1:2])
			rd_word[PD_LSB +: PD_W] = pd_ctl_r;
		if (s_axi_araddr[AW-1:2] == OFS_PD_OUT[AW-1:2])
			rd_word[PD_LSB +: PD_W] = pd_out_r;
		if (s_axi_araddr[AW-1:2] == OFS_PE_DIR[AW-1:2])
			rd_word[PE_W-1:0] = pe_dir_r;
		if (s_axi_araddr[AW-1:2] == OFS_PE_CTL[AW-1:2])
			rd_word[PE_W-1:0] = pe_ctl_r;
		if (s_axi_araddr[AW-1:2] == OFS_PE_OUT[AW-1:2])
			rd_word[PE_W-1:0] = pe_out_r;
		if (s_axi_araddr[AW-1:2] == OFS_PIN_LVL[AW-1:2])
			rd_word[NPIN-1:0] = lvl;
		for (int i = 0; i < TM_N; i++) begin
			if ({s_axi_araddr[AW-1:2], 2'h0} == tm_ofs(i)) begin
				rd_word[TM_MODE_LSB +: TM_MODE_W] = tm_mode_r[i];
				rd_word[TM_GDIR_BIT] = tm_gdir_r[i];
				rd_word[TM_GOUT_BIT] = tm_gout_r[i];
				rd_word[TM_LVL_BIT] = lvl[PIN_TM0+i];
			end
		end
	end

	always_comb begin
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;
		if (ar_fire) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = rd_word;
			rresp_nxt = addr_ok({s_axi_araddr[AW-1:2], 2'h0}) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// all pins come out of reset as gpio
	always_ff @(posedge core_clk) begin
		if (srst) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= '0;
			w_have_r <= 1'b0;
			w_data_r <= '0;
			w_lane0_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= '0;
			pd_dir_r <= RST_PD;
			pd_ctl_r <= RST_PD;
			pd_out_r <= RST_PD;
			pe_dir_r <= RST_PE;
			pe_ctl_r <= RST_PE;
			pe_out_r <= RST_PE;
			tm_mode_r <= '{default: RST_TM_MODE};
			tm_gdir_r <= '0;
			tm_gout_r <= '0;
		end else begin
			aw_have_r <= aw_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_have_r <= w_have_nxt;
			w_data_r <= w_data_nxt;
			w_lane0_r <= w_lane0_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			pd_dir_r <= pd_dir_nxt;
			pd_ctl_r <= pd_ctl_nxt;
			pd_out_r <= pd_out_nxt;
			pe_dir_r <= pe_dir_nxt;
			pe_ctl_r <= pe_ctl_nxt;
			pe_out_r <= pe_out_nxt;
			tm_mode_r <= tm_mode_nxt;
			tm_gdir_r <= tm_gdir_nxt;
			tm_gout_r <= tm_gout_nxt;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	// ----------------------------------------
	// per-pin source selection
	// ----------------------------------------
	always_comb begin
		sel[PIN_PD5:PIN_PD4] = pd_ctl_r;
		gdir[PIN_PD5:PIN_PD4] = pd_dir_r;
		gout[PIN_PD5:PIN_PD4] = pd_out_r;
		sel[PIN_PE2:PIN_PE0] = pe_ctl_r;
		gdir[PIN_PE2:PIN_PE0] = pe_dir_r;
		gout[PIN_PE2:PIN_PE0] = pe_out_r;
		poe[PIN_PD4] = 1'b0;
		pout[PIN_PD4] = 1'b0;
		poe[PIN_PD5] = sync_tx_busy;
		pout[PIN_PD5] = sync_tx_data;
		// full duplex: rx in, tx always out
		poe[PIN_PE0] = 1'b0;
		pout[PIN_PE0] = 1'b0;
		poe[PIN_PE1] = 1'b1;
		pout[PIN_PE1] = async_tx_data;
		// clock direction chosen by the interface
		poe[PIN_PE2] = async_clk_drive;
		pout[PIN_PE2] = async_clk_out;
		for (int i = 0; i < TM_N; i++) begin
			sel[PIN_TM0+i] = tm_periph(tm_mode_r[i]);
			gdir[PIN_TM0+i] = tm_gdir_r[i];
			gout[PIN_TM0+i] = tm_gout_r[i];
			poe[PIN_TM0+i] = tm_drives(tm_mode_r[i]);
			pout[PIN_TM0+i] = timer_out[i];
		end
	end

	assign pin_i = {timer_two_pin_i, timer_one_pin_i, timer_zero_pin_i, porte_bit_two_i,
		porte_bit_one_i, porte_bit_zero_i, portd_bit_five_i, portd_bit_four_i};

	for (genvar g = 0; g < NPIN; g++) begin : g_pin
		stps_pin_cell u_cell (
			.core_clk(core_clk),
			.srst(srst),
			.sel(sel[g]),
			.gpio_dir(gdir[g]),
			.gpio_out(gout[g]),
			.per_oe(poe[g]),
			.per_out(pout[g]),
			.pin_i(pin_i[g]),
			.pin_o(pin_o[g]),
			.pin_oe(pin_oe[g]),
			.lvl(lvl[g]),
			.per_in(per_in[g])
		);
	end

	assign portd_bit_four_o = pin_o[PIN_PD4];
	assign portd_bit_four_oe = pin_oe[PIN_PD4];
	assign portd_bit_five_o = pin_o[PIN_PD5];
	assign portd_bit_five_oe = pin_oe[PIN_PD5];
	assign porte_bit_zero_o = pin_o[PIN_PE0];
	assign porte_bit_zero_oe = pin_oe[PIN_PE0];
	assign porte_bit_one_o = pin_o[PIN_PE1];
	assign porte_bit_one_oe = pin_oe[PIN_PE1];
	assign porte_bit_two_o = pin_o[PIN_PE2];
	assign porte_bit_two_oe = pin_oe[PIN_PE2];
	assign timer_zero_pin_o = pin_o[PIN_TM0];
	assign timer_zero_pin_oe = pin_oe[PIN_TM0];
	assign timer_one_pin_o = pin_o[PIN_TM0+1];
	assign timer_one_pin_oe = pin_oe[PIN_TM0+1];
	assign timer_two_pin_o = pin_o[PIN_TM0+2];
	assign timer_two_pin_oe = pin_oe[PIN_TM0+2];
	// peripheral inputs read zero while the pin is gpio
	assign sync_rx_data = per_in[PIN_PD4];
	assign async_rx_data = per_in[PIN_PE0];
	assign async_clk_in = per_in[PIN_PE2];
	assign timer_in = per_in[PIN_TM0 +: TM_N];
	assign timer_mode = {tm_mode_r[2], tm_mode_r[1], tm_mode_r[0]};

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence s_pd_rx_claim;
		wr_fire && w_lane0_r && aw_addr_r == OFS_PD_CTL && w_data_r[PD_LSB];
	endsequence
	sequence s_pd_rx_listen;
		pd_ctl_r[0] ##1 !portd_bit_four_oe;
	endsequence

	AST_PD_RESET: assert property ($past(srst) |-> !portd_bit_four_oe && !portd_bit_five_oe && pd_ctl_r == '0)
		else $error("port D pin not gpio input after reset");
	AST_PD_GPIO_DIR: assert property (!pd_ctl_r[1] |=> portd_bit_five_oe == $past(pd_dir_r[1]))
		else $error("port D gpio direction not followed");
	AST_PD_CLAIM: assert property (s_pd_rx_claim |-> ##1 s_pd_rx_listen)
		else $error("port D control write did not claim receive pin");
	AST_PD_RX_IN: assert property (pd_ctl_r[0] && pd_dir_r[0] |=> !portd_bit_four_oe)
		else $error("sync receive pin driven");
	AST_PD_TX_OUT: assert property (pd_ctl_r[1] |=> portd_bit_five_oe == $past(sync_tx_busy)
		&& portd_bit_five_o == $past(sync_tx_data))
		else $error("sync transmit pin not following port");
	AST_PE_GPIO: assert property (!pe_ctl_r[0] |=> porte_bit_zero_oe == $past(pe_dir_r[0]))
		else $error("port E gpio direction not followed");
	AST_PE_TX: assert property (pe_ctl_r[1] |=> porte_bit_one_oe && porte_bit_one_o == $past(async_tx_data))
		else $error("async transmit pin not driven");
	AST_PE_CLK: assert property (pe_ctl_r[2] |=> porte_bit_two_oe == $past(async_clk_drive))
		else $error("async clock pin direction wrong");
	AST_PE_RX_IN: assert property (pe_ctl_r[0] ##1 pe_ctl_r[0] |-> !porte_bit_zero_oe
		&& async_rx_data == $past(porte_bit_zero_i))
		else $error("async receive pin not routed");
	AST_TM_IN: assert property ((tm_mode_r[0] == TM_EVENT || tm_mode_r[0] == TM_MEAS) |=> !timer_zero_pin_oe)
		else $error("timer input mode drives pin");
	AST_TM_OUT: assert property (tm_drives(tm_mode_r[1]) |=> timer_one_pin_oe
		&& timer_one_pin_o == $past(timer_out[1]))
		else $error("timer output mode not driving pin");
	AST_TM_RESET: assert property ($past(srst) |-> !timer_two_pin_oe && tm_mode_r[2] == TM_GPIO)
		else $error("timer pin not gpio input after reset");
	AST_PIN_OWN: assert property (tm_periph(tm_mode_r[2]) && !tm_drives(tm_mode_r[2]) && tm_gdir_r[2]
		|=> !timer_two_pin_oe)
		else $error("gpio direction leaked into timer input");
	AST_TM_INDEP: assert property (tm_mode_r[0] == TM_GPIO && tm_drives(tm_mode_r[1])
		|=> timer_zero_pin_oe == $past(tm_gdir_r[0]))
		else $error("timers not independent");
	AST_AXI_B: assert property (wr_fire |=> s_axi_bvalid)
		else $error("write response missing");
endmodule
`default_nettype wire

// File: tb/stps_far_model.sv
// far-side model of the serial peers and timer devices
`timescale 1ns/10ps
`default_nettype none
module stps_far_model (
	// device side of the pins
	input wire logic [7:0] dev_o,
	input wire logic [7:0] dev_oe,
	// far-side drive pattern
	input wire logic [7:0] far_val,
	// resolved pin levels
	output logic [7:0] lvl
);
	// ----
	// pin resolution
	// ----
	// peers drive released pins
	assign lvl = (dev_oe & dev_o) | (~dev_oe & far_val);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the serial/timer pin function select
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import stps_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] awaddr = 8'h0;
	logic [7:0] araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [7:0] far_val = 8'h0;
	logic [7:0] per_v = 8'h0;
	wire awready, wready, bvalid, arready, rvalid, sync_rx, async_rx, async_ci;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] po, poe, pw;
	wire [8:0] tmode;
	wire [2:0] t_in;
	int failures = 0;
	int n_checks = 0;
	logic [31:0] sh [0:8];
	initial forever #2.5 core_clk = ~core_clk;
	stps_pin_select stps_pin_select_inst (.core_clk(core_clk), .srst(srst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .portd_bit_four_i(pw[0]), .portd_bit_four_o(po[0]), .portd_bit_four_oe(poe[0]),
		.portd_bit_five_i(pw[1]), .portd_bit_five_o(po[1]), .portd_bit_five_oe(poe[1]),
		.porte_bit_zero_i(pw[2]), .porte_bit_zero_o(po[2]), .porte_bit_zero_oe(poe[2]),
		.porte_bit_one_i(pw[3]), .porte_bit_one_o(po[3]), .porte_bit_one_oe(poe[3]),
		.porte_bit_two_i(pw[4]), .porte_bit_two_o(po[4]), .porte_bit_two_oe(poe[4]),
		.timer_zero_pin_i(pw[5]), .timer_zero_pin_o(po[5]), .timer_zero_pin_oe(poe[5]),
		.timer_one_pin_i(pw[6]), .timer_one_pin_o(po[6]), .timer_one_pin_oe(poe[6]),
		.timer_two_pin_i(pw[7]), .timer_two_pin_o(po[7]), .timer_two_pin_oe(poe[7]),
		.sync_rx_data(sync_rx), .sync_tx_busy(per_v[0]), .sync_tx_data(per_v[1]), .async_rx_data(async_rx),
		.async_tx_data(per_v[2]), .async_clk_drive(per_v[3]), .async_clk_out(per_v[4]),
		.async_clk_in(async_ci), .timer_mode(tmode), .timer_out(per_v[7:5]), .timer_in(t_in));
	stps_far_model stps_far_model_inst (.dev_o(po), .dev_oe(poe), .far_val(far_val), .lvl(pw));
	// ----
	// expectations
	// ----
	function automatic logic [31:0] msk(input int i);
		return (i < 3) ? 32'h30 : (i < 6) ? 32'h7 : 32'h37;
	endfunction
	function automatic logic [15:0] exp_pins();
		logic [7:0] oe;
		logic [7:0] o;
		logic [2:0] m;
		for (int i = 0; i < 2; i++) begin
			oe[i] = sh[1][4+i] ? (i == 1 && per_v[0]) : sh[0][4+i];
			o[i] = sh[1][4+i] ? per_v[1] : sh[2][4+i];
		end
		for (int i = 0; i < 3; i++) begin
			oe[2+i] = sh[4][i] ? (i == 1 || (i == 2 && per_v[3])) : sh[3][i];
			o[2+i] = sh[4][i] ? per_v[(i == 1) ? 2 : 4] : sh[5][i];
			m = sh[6+i][2:0];
			oe[5+i] = (m inside {[TM_TIMER:TM_WDOG]}) || (!(m inside {[TM_TIMER:TM_MEAS]}) && sh[6+i][4]);
			o[5+i] = (m inside {[TM_TIMER:TM_WDOG]}) ? per_v[5+i] : sh[6+i][5];
		end
		return {oe, o & oe};
	endfunction
	function automatic logic [7:0] exp_wire();
		logic [15:0] e;
		e = exp_pins();
		return (e[15:8] & e[7:0]) | (~e[15:8] & far_val);
	endfunction
	function automatic logic [14:0] exp_per();
		logic [7:0] w;
		logic [2:0] ti;
		w = exp_wire();
		for (int i = 0; i < 3; i++) ti[i] = w[5+i] && (sh[6+i][2:0] inside {[TM_TIMER:TM_MEAS]});
		return {sh[1][4] & w[0], sh[4][0] & w[2], sh[4][2] & w[4], ti, sh[8][2:0], sh[7][2:0], sh[6][2:0]};
	endfunction
	function automatic logic [31:0] exp_reg(input int i);
		logic [7:0] w;
		w = exp_wire();
		if (i >= 6 && i < 9) return sh[i] | {23'h0, w[i-1], 8'h0};
		return (i < 6) ? sh[i] : (i == 9) ? {24'h0, w} : 32'h0;
	endfunction
	// ----
	// compare and report
	// ----
	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value pins at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value register at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// ----
	// bus tasks, entered just after a rising edge
	// ----
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		int k;
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		r = 2'h3;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge core_clk);
			if (ad && wd && bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
			if (!ad && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		if (k == 64) begin
			failures++;
			summarize();
		end
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		logic ad;
		ad = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge core_clk);
			if (ad && rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
			if (!ad && arready) begin
				ad = 1'b1;
				arvalid <= 1'b0;
			end
		end
		if (k == 64) begin
			failures++;
			summarize();
		end
		@(posedge core_clk);
	endtask
	task automatic wreg(input int i, input logic [31:0] d);
		logic [1:0] r;
		wr(8'(i * 4), d, 4'hf, r);
		chk_reg({30'h0, r}, {30'h0, RESP_OKAY});
		sh[i] = d & msk(i);
	endtask
	// settle, then pins, peripheral side and every register plus one unmapped word
	task automatic check_all();
		logic [31:0] d;
		logic [1:0] r;
		repeat (4) @(posedge core_clk);
		chk_pin({16'h0, poe, po & poe}, {16'h0, exp_pins()});
		chk_pin({17'h0, sync_rx, async_rx, async_ci, t_in, tmode}, {17'h0, exp_per()});
		for (int i = 0; i < 11; i++) begin
			rd(8'(i * 4), d, r);
			chk_reg(d, exp_reg(i));
			chk_reg({30'h0, r}, {30'h0, (i < 10) ? RESP_OKAY : RESP_SLVERR});
		end
	endtask
	initial begin
		logic [1:0] r;
		logic [31:0] d;
		void'($urandom(50198));
		for (int i = 0; i < 9; i++) sh[i] = 32'h0;
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		check_all();
		$display("test reset_defaults done");
		for (int n = 0; n < 20; n++) begin
			wreg(0, $urandom);
			wreg(2, $urandom);
			wreg(3, $urandom);
			wreg(5, $urandom);
			d = $urandom;
			d[2:0] = (n % 3 == 0) ? 3'h0 : (n % 3 == 1) ? 3'h6 : 3'h7;
			wreg(6 + n % 3, d);
			far_val <= 8'($urandom);
			per_v <= 8'($urandom);
			check_all();
		end
		$display("test gpio_direction done");
		for (int n = 0; n < 60; n++) begin
			wreg($urandom % 9, $urandom);
			far_val <= 8'($urandom);
			per_v <= 8'($urandom);
			check_all();
		end
		$display("test random_select done");
		for (int m = 0; m < 8; m++) begin
			for (int i = 0; i < 3; i++) wreg(6 + i, {26'h0, 1'($urandom), 2'h2, 3'(m)});
			check_all();
		end
		$display("test timer_modes done");
		wr(8'h28, 32'hffff_ffff, 4'hf, r);
		chk_reg({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(OFS_PIN_LVL, 32'hff, 4'hf, r);
		chk_reg({30'h0, r}, {30'h0, RESP_OKAY});
		wreg(0, 32'h30);
		wreg(1, 32'h30);
		wr(OFS_PD_CTL, 32'h0, 4'h0, r);
		chk_reg({30'h0, r}, {30'h0, RESP_OKAY});
		// low address bits are ignored, only lane 0 matters
		wr(8'h01, 32'h10, 4'h1, r);
		chk_reg({30'h0, r}, {30'h0, RESP_OKAY});
		sh[0] = 32'h10;
		per_v <= 8'h0;
		check_all();
		rd(8'h12, d, r);
		chk_reg(d, exp_reg(4));
		chk_reg({30'h0, r}, {30'h0, RESP_OKAY});
		$display("test refused_writes done");
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		for (int i = 0; i < 9; i++) sh[i] = 32'h0;
		@(posedge core_clk);
		check_all();
		$display("test mid_reset done");
		summarize();
	end
endmodule
`default_nettype wire
